// file: sim/actrx_chk.sv
// Port-level assertions for the serial channel control block
`default_nettype none
module actrx_chk
	import actrx_pkg::*;
(
	input wire logic        clock_in,
	input wire logic        rst_b_in,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [1:0]  s_axi_bresp_out,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic        tx_busy_in,
	input wire logic        rts_b_out,
	input wire logic        rx_char_valid_in,
	input wire logic [7:0]  rx_char_in,
	input wire logic        rx_fifo_wr_out,
	input wire logic [7:0]  rx_fifo_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	a_rts_busy: assert property (tx_busy_in |=> !rts_b_out)
		else $error("send request inactive while transmitting");
	a_fifo_copy: assert property (rx_char_valid_in |=> rx_fifo_wr_out &&
		rx_fifo_data_out == $past(rx_char_in)) else $error("character not stored");
	a_fifo_quiet: assert property (!rx_char_valid_in |=> !rx_fifo_wr_out)
		else $error("store without character");
	a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
		&& $stable(s_axi_bresp_out)) else $error("write response dropped");
	a_b_done: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
		else $error("write response repeated");
	a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
		&& $stable(s_axi_rdata_out)) else $error("read data dropped");
	a_read_lat: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");
	a_ar_block: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("address taken during read answer");
endmodule : actrx_chk

bind actrx_top actrx_chk i_actrx_chk(.clock_in, .rst_b_in, .s_axi_bvalid_out, .s_axi_bready_in,
	.s_axi_bresp_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in,
	.s_axi_rdata_out, .tx_busy_in, .rts_b_out, .rx_char_valid_in, .rx_char_in, .rx_fifo_wr_out,
	.rx_fifo_data_out);
`default_nettype wire

// file: sim/actrx_remote.sv
// Remote station model: line level and received character reports
`default_nettype none
module actrx_remote (
	input  wire logic       clock_in,
	output logic            line_out,
	output logic            valid_out,
	output logic [7:0]      char_out,
	output logic            frame_ok_out,
	output logic            parity_ok_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		line_out = 1'b1;
		valid_out = 1'b0;
		char_out = 8'h00;
		frame_ok_out = 1'b0;
		parity_ok_out = 1'b0;
	end
	// Fields are scrambled outside the valid cycle
	task send(input logic [7:0] c, input logic f, input logic p);
		@(posedge clock_in);
		valid_out <= 1'b1;
		char_out <= c;
		frame_ok_out <= f;
		parity_ok_out <= p;
		@(posedge clock_in);
		valid_out <= 1'b0;
		char_out <= ~c;
		frame_ok_out <= ~f;
		parity_ok_out <= ~p;
	endtask : send
endmodule : actrx_remote
`default_nettype wire

// file: sim/actrx_tb.sv
// Self-checking bench for the serial channel control block
`default_nettype none
`include "actrx_defines.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch at %0t: got %h want %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 1'b0, rst_b_in = 1'b0, tx_busy_in = 1'b0, tx_serial_in = 1'b1;
	logic tx_clk_tick_in = 1'b0, stop_char_in = 1'b0, s_axi_bready_in = 1'b0;
	logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
	logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
	logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in = 4'hf;
	logic rx_line_in, rx_char_valid_in, rx_frame_ok_in, rx_parity_ok_in;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, tx_line_out, tx_enable_out, rts_b_out, rx_serial_out;
	logic rx_active_out, rx_fifo_wr_out, sample_tick_out, bit_tick_out, irq_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, tc = 2'h0;
	logic [7:0] rx_char_in, rx_fifo_data_out;
	int miscompares = 0, num_checks = 0;

	always #25 clock_in = ~clock_in;
	// Transmit clock at a quarter of the system clock
	always @(posedge clock_in) begin
		tc <= tc + 2'h1;
		tx_clk_tick_in <= (tc == 2'h3);
	end

	actrx_top i_actrx_top(.clock_in, .rst_b_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
		.s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
		.s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
		.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
		.s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .tx_busy_in, .tx_serial_in,
		.tx_clk_tick_in, .stop_char_in, .tx_line_out, .tx_enable_out, .rts_b_out,
		.rx_line_in, .rx_serial_out, .rx_active_out, .rx_char_valid_in, .rx_char_in,
		.rx_frame_ok_in, .rx_parity_ok_in, .rx_fifo_wr_out, .rx_fifo_data_out,
		.sample_tick_out, .bit_tick_out, .irq_out);
	actrx_remote i_actrx_remote(.clock_in, .line_out(rx_line_in), .valid_out(rx_char_valid_in),
		.char_out(rx_char_in), .frame_ok_out(rx_frame_ok_in), .parity_ok_out(rx_parity_ok_in));

	task close_out;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task settle;
		repeat (2) @(posedge clock_in);
		@(negedge clock_in);
	endtask : settle

	task wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a, w, b, r;
		logic [1:0] rs;
		int n;
		@(posedge clock_in);
		s_axi_awaddr_in <= idx << 2;
		s_axi_wdata_in <= {24'h0, d};
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge clock_in);
			a = s_axi_awvalid_in && s_axi_awready_out;
			w = s_axi_wvalid_in && s_axi_wready_out;
			b = s_axi_bvalid_out;
			r = s_axi_bready_in;
			rs = s_axi_bresp_out;
			@(posedge clock_in);
			if (a) s_axi_awvalid_in <= 1'b0;
			if (w) s_axi_wvalid_in <= 1'b0;
			if (b && r) break;
			if (b) s_axi_bready_in <= 1'b1;
		end
		s_axi_bready_in <= 1'b0;
		if (n == 40) begin
			miscompares++;
			close_out();
		end
		`CHK(rs, er)
	endtask : wr

	task rchk(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
		logic a, b, r;
		logic [31:0] d;
		logic [1:0] rs;
		int n;
		@(posedge clock_in);
		s_axi_araddr_in <= idx << 2;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(negedge clock_in);
			a = s_axi_arvalid_in && s_axi_arready_out;
			b = s_axi_rvalid_out;
			r = s_axi_rready_in;
			d = s_axi_rdata_out;
			rs = s_axi_rresp_out;
			@(posedge clock_in);
			if (a) s_axi_arvalid_in <= 1'b0;
			if (b && r) break;
			if (b) s_axi_rready_in <= 1'b1;
		end
		s_axi_rready_in <= 1'b0;
		if (n == 40) begin
			miscompares++;
			close_out();
		end
		`CHK(d, {24'h0, e})
		`CHK(rs, er)
	endtask : rchk

	task t_regs;
		`CHK(rts_b_out, 1'b1)
		rchk(`ACTRX_IDX_RESUME, `ACTRX_RST_RESUME, `ACTRX_RESP_OKAY);
		rchk(`ACTRX_IDX_MODE, `ACTRX_RST_MODE, `ACTRX_RESP_OKAY);
		rchk(8'h01, 8'h00, `ACTRX_RESP_SLVERR);
		wr(8'h01, 8'h5a, `ACTRX_RESP_SLVERR);
		wr(`ACTRX_IDX_RESUME, 8'h3c, `ACTRX_RESP_OKAY);
		rchk(`ACTRX_IDX_RESUME, 8'h3c, `ACTRX_RESP_OKAY);
		s_axi_wstrb_in <= 4'he;
		wr(`ACTRX_IDX_RESUME, 8'h77, `ACTRX_RESP_OKAY);
		s_axi_wstrb_in <= 4'hf;
		rchk(`ACTRX_IDX_RESUME, 8'h3c, `ACTRX_RESP_OKAY);
	endtask : t_regs

	task t_rts;
		tx_busy_in <= 1'b1;
		settle();
		`CHK(rts_b_out, 1'b0)
		@(posedge clock_in);
		tx_busy_in <= 1'b0;
		settle();
		`CHK(rts_b_out, 1'b1)
		wr(`ACTRX_IDX_MODE, 8'h04, `ACTRX_RESP_OKAY);
		settle();
		`CHK(rts_b_out, 1'b0)
		wr(`ACTRX_IDX_MODE, 8'h00, `ACTRX_RESP_OKAY);
		settle();
		`CHK(rts_b_out, 1'b1)
	endtask : t_rts

	task t_loop;
		wr(`ACTRX_IDX_MODE, 8'h09, `ACTRX_RESP_OKAY);
		tx_serial_in <= 1'b0;
		settle();
		`CHK(rx_serial_out, 1'b0)
		`CHK(tx_line_out, 1'b1)
		`CHK(rx_active_out, 1'b1)
		wr(`ACTRX_IDX_MODE, 8'h00, `ACTRX_RESP_OKAY);
		settle();
		`CHK(rx_serial_out, 1'b1)
		`CHK(tx_line_out, 1'b0)
		`CHK(rx_active_out, 1'b0)
		@(posedge clock_in);
		tx_serial_in <= 1'b1;
	endtask : t_loop

	// Clocks from restart (rp high) or from the last interrupt (rp low) to the next, near p
	task t_timer(input logic [7:0] md, input logic [7:0] cf, input logic [7:0] tm, input int p,
		input logic rp);
		int n;
		if (rp) begin
			wr(`ACTRX_IDX_IMR, 8'h01, `ACTRX_RESP_OKAY);
			wr(`ACTRX_IDX_CFG, cf, `ACTRX_RESP_OKAY);
			wr(`ACTRX_IDX_MODE, md, `ACTRX_RESP_OKAY);
			wr(`ACTRX_IDX_TIMER, tm, `ACTRX_RESP_OKAY);
		end
		rchk(`ACTRX_IDX_ISR, 8'h00, `ACTRX_RESP_OKAY);
		@(negedge clock_in);
		for (n = 0; n < p + 12 && irq_out !== 1'b1; n++)
			@(negedge clock_in);
		`CHK(n > p - 40 && n < p + 12, 1'b1)
		if (n == p + 12)
			close_out();
		rchk(`ACTRX_IDX_ISR, 8'h01, `ACTRX_RESP_OKAY);
		settle();
		`CHK(irq_out, 1'b0)
	endtask : t_timer

	task res_case(input logic [7:0] cf, input logic [7:0] c, input logic f, p, e);
		wr(`ACTRX_IDX_CFG, cf, `ACTRX_RESP_OKAY);
		i_actrx_remote.send(c, f, p);
		settle();
		`CHK(irq_out, e)
		rchk(`ACTRX_IDX_ISR, {6'h0, e, 1'b0}, `ACTRX_RESP_OKAY);
	endtask : res_case

	task stop_pulse;
		@(posedge clock_in);
		stop_char_in <= 1'b1;
		@(posedge clock_in);
		stop_char_in <= 1'b0;
		settle();
	endtask : stop_pulse

	task t_flow;
		stop_pulse();
		`CHK(tx_enable_out, 1'b1)
		wr(`ACTRX_IDX_MODE, 8'h10, `ACTRX_RESP_OKAY);
		stop_pulse();
		`CHK(tx_enable_out, 1'b0)
		i_actrx_remote.send(8'h12, 1'b1, 1'b1);
		settle();
		`CHK(tx_enable_out, 1'b0)
		i_actrx_remote.send(8'h11, 1'b1, 1'b1);
		settle();
		`CHK(tx_enable_out, 1'b1)
	endtask : t_flow

	// Reset in mid-run clears the pending interrupt and the baud setting
	task t_reset;
		@(posedge clock_in);
		rst_b_in <= 1'b0;
		settle();
		`CHK(irq_out, 1'b0)
		`CHK(s_axi_awready_out, 1'b0)
		@(posedge clock_in);
		rst_b_in <= 1'b1;
		settle();
		rchk(`ACTRX_IDX_BAUD, `ACTRX_RST_BAUD, `ACTRX_RESP_OKAY);
		rchk(`ACTRX_IDX_ISR, 8'h00, `ACTRX_RESP_OKAY);
	endtask : t_reset

	task t_baud;
		int ns, nb;
		wr(`ACTRX_IDX_BAUD, 8'h01, `ACTRX_RESP_OKAY);
		settle();
		ns = 0;
		nb = 0;
		repeat (320) begin
			@(negedge clock_in);
			ns += sample_tick_out;
			nb += bit_tick_out;
		end
		`CHK(ns, 160)
		`CHK(nb, 10)
	endtask : t_baud

	initial begin
		repeat (2) @(posedge clock_in);
		rst_b_in <= 1'b1;
		repeat (3) @(posedge clock_in);
		t_regs();
		t_rts();
		t_loop();
		t_timer(8'h02, 8'h0d, 8'he0, 512, 1'b1);
		t_timer(8'h02, 8'h0d, 8'h00, 512, 1'b0);
		t_timer(8'h02, 8'h0d, 8'he3, 2048, 1'b1);
		t_timer(8'h02, 8'h0f, 8'he0, 2048, 1'b1);
		t_timer(8'h02, 8'h0c, 8'he0, 2048, 1'b1);
		t_timer(8'h02, 8'h0d, 8'h21, 17408, 1'b1);
		repeat (1100) @(negedge clock_in);
		`CHK(irq_out, 1'b0)
		t_timer(8'h00, 8'h0d, 8'h00, 32768, 1'b1);
		wr(`ACTRX_IDX_RESUME, 8'h11, `ACTRX_RESP_OKAY);
		wr(`ACTRX_IDX_IMR, 8'h02, `ACTRX_RESP_OKAY);
		res_case(8'h1c, 8'h11, 1'b1, 1'b1, 1'b1);
		res_case(8'h1c, 8'h11, 1'b1, 1'b0, 1'b0);
		res_case(8'h1c, 8'h11, 1'b0, 1'b1, 1'b0);
		res_case(8'h0c, 8'h11, 1'b1, 1'b0, 1'b1);
		res_case(8'h1c, 8'h91, 1'b1, 1'b1, 1'b0);
		res_case(8'h00, 8'hf1, 1'b1, 1'b1, 1'b1);
		res_case(8'h00, 8'h12, 1'b1, 1'b1, 1'b0);
		t_flow();
		t_baud();
		t_reset();
		close_out();
	end
endmodule : testbench
`default_nettype wire

// file: src/actrx_defines.svh
// Register map, field positions, reset values and timer constants for the serial channel block
`ifndef ACTRX_DEFINES_SVH
`define ACTRX_DEFINES_SVH

// Register indices; byte address is four times the index
`define ACTRX_IDX_MODE      8'h20
`define ACTRX_IDX_TIMER     8'h23
`define ACTRX_IDX_RESUME    8'h24
`define ACTRX_IDX_CFG       8'h28
`define ACTRX_IDX_ISR       8'h29
`define ACTRX_IDX_IMR       8'h2a
`define ACTRX_IDX_STAT      8'h2b
`define ACTRX_IDX_BAUD      8'h2c

// Mode register fields
`define ACTRX_MODE_LOOP     0
`define ACTRX_MODE_TRS      1
`define ACTRX_MODE_RTS      2
`define ACTRX_MODE_RAC      3
`define ACTRX_MODE_INBAND_FLOW_ENABLE     4

// Configuration register fields
`define ACTRX_CFG_MCE       0
`define ACTRX_CFG_CRYSTAL_DIVIDE_SELECT      1
`define ACTRX_CFG_LEN_LO    2
`define ACTRX_CFG_LEN_HI    3
`define ACTRX_CFG_PAR_EN    4

// Interrupt status and mask fields
`define ACTRX_INT_TIMER     0
`define ACTRX_INT_RESUME    1

// Timer period field layout
`define ACTRX_TMR_VAL_HI    4
`define ACTRX_TMR_CNT_LO    5
`define ACTRX_TMR_CNT_HI    7
`define ACTRX_TMR_PERIODIC  3'h7

// Timer factor k minus one
`define ACTRX_K_COARSE_M1   15'h7fff
`define ACTRX_K_FINE_M1     15'h01ff

// Oversampling factor of the baud generator, minus one
`define ACTRX_OVS_M1        4'hf

// Reset values
`define ACTRX_RST_MODE      8'h00
`define ACTRX_RST_TIMER     8'h00
`define ACTRX_RST_RESUME    8'h00
`define ACTRX_RST_CFG       8'h00
`define ACTRX_RST_BAUD      8'h00

// Bus responses
`define ACTRX_RESP_OKAY     2'h0
`define ACTRX_RESP_SLVERR   2'h2

`endif

// file: src/actrx_pkg.sv
// Types shared by the serial channel timer, request-to-send and resume-character block
`default_nettype none
package actrx_pkg;
	typedef enum logic [0:0] {
		ACTRX_TMR_IDLE = 1'b0,
		ACTRX_TMR_RUN  = 1'b1
	} actrx_tmr_state_t;
endpackage : actrx_pkg
`default_nettype wire

// file: src/actrx_top.sv
// Serial channel control: request-to-send, test loop, timer, baud ticks, resume character
`default_nettype none
`include "actrx_defines.svh"

// Contract
// RULE_01 - Control bit clear: send request follows transmission
// RULE_02 - Control bit set: send request held active
// RULE_03 - Resolution bit picks k 32768 or 512
// RULE_04 - Test loop feeds transmitter into own receiver
// RULE_05 - First period is k times (value+1)
// RULE_06 - Second period adds 32*k*multiplier; interrupt then
// RULE_07 - Multiplier seven: interrupt at every first period
// RULE_08 - No master clock: timer runs on transmit clock
// RULE_09 - Master clock, no divide: timer on crystal
// RULE_10 - Master clock, divide set: crystal over four
// RULE_11 - Crystal drives baud generator with 16x oversample
// RULE_12 - Resume compare uses character length, right-justified
// RULE_13 - Match needs framing, unmasked bits, correct parity
// RULE_14 - Resume characters still go to receive FIFO
// RULE_15 - Recognition sets dedicated resume interrupt flag
// RULE_16 - Flow control on: resume restarts stopped transmitter
module actrx_top
	import actrx_pkg::*;
(
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// Transmitter side
	input  wire logic        tx_busy_in,
	input  wire logic        tx_serial_in,
	input  wire logic        tx_clk_tick_in,
	input  wire logic        stop_char_in,
	output logic             tx_line_out,
	output logic             tx_enable_out,
	output logic             rts_b_out,
	// Receiver side
	input  wire logic        rx_line_in,
	output logic             rx_serial_out,
	output logic             rx_active_out,
	input  wire logic        rx_char_valid_in,
	input  wire logic [7:0]  rx_char_in,
	input  wire logic        rx_frame_ok_in,
	input  wire logic        rx_parity_ok_in,
	output logic             rx_fifo_wr_out,
	output logic [7:0]       rx_fifo_data_out,
	// Baud generator ticks
	output logic             sample_tick_out,
	output logic             bit_tick_out,
	// Interrupt
	output logic             irq_out
);

	logic [7:0]       mode_r;
	logic [7:0]       timer_set_r;
	logic [7:0]       resume_r;
	logic [7:0]       cfg_r;
	logic [7:0]       baud_r;
	logic [1:0]       isr_r;
	logic [1:0]       imr_r;
	logic [1:0]       isr_nxt;

	logic             aw_hold_r;
	logic [7:0]       aw_addr_r;
	logic             w_hold_r;
	logic [31:0]      w_data_r;
	logic             w_strb0_r;
	logic             wr_do;
	logic [7:0]       wr_idx;
	logic             ar_take;
	logic [7:0]       rd_idx;
	logic [31:0]      rd_data;
	logic             rd_ok;
	logic             wr_ok;

	logic             xoff_state_r;
	logic             resume_hit;
	logic [7:0]       len_mask;

	logic [1:0]       xtal_div_r;
	logic             tmr_tick;
	actrx_tmr_state_t tmr_state_r;
	logic [14:0]      tmr_pre_r;
	logic [7:0]       tmr_units_r;
	logic [7:0]       tmr_units_nxt;
	logic [14:0]      k_m1;
	logic [7:0]       t1_units;
	logic [7:0]       t2_units;
	logic             tmr_periodic;
	logic             tmr_fire_r;

	logic [7:0]       baud_cnt_r;
	logic [3:0]       ovs_cnt_r;

	assign wr_idx = {2'h0, aw_addr_r[7:2]};
	assign rd_idx = {2'h0, s_axi_araddr_in[7:2]};
	assign wr_do  = aw_hold_r & w_hold_r & ~s_axi_bvalid_out;
	assign ar_take = s_axi_arvalid_in & s_axi_arready_out;

	// Write address channel
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			aw_hold_r         <= 1'b0;
			aw_addr_r         <= 8'h00;
			s_axi_awready_out <= 1'b0;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_hold_r         <= 1'b1;
			aw_addr_r         <= s_axi_awaddr_in;
			s_axi_awready_out <= 1'b0;
		end else if (wr_do) begin
			aw_hold_r         <= 1'b0;
			s_axi_awready_out <= 1'b1;
		end else if (!aw_hold_r) begin
			s_axi_awready_out <= 1'b1;
		end
	end

	// Write data channel
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			w_hold_r         <= 1'b0;
			w_data_r         <= 32'h0000_0000;
			w_strb0_r        <= 1'b0;
			s_axi_wready_out <= 1'b0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_hold_r         <= 1'b1;
			w_data_r         <= s_axi_wdata_in;
			w_strb0_r        <= s_axi_wstrb_in[0];
			s_axi_wready_out <= 1'b0;
		end else if (wr_do) begin
			w_hold_r         <= 1'b0;
			s_axi_wready_out <= 1'b1;
		end else if (!w_hold_r) begin
			s_axi_wready_out <= 1'b1;
		end
	end

	always_comb begin
		unique case (wr_idx)
			`ACTRX_IDX_MODE, `ACTRX_IDX_TIMER, `ACTRX_IDX_RESUME, `ACTRX_IDX_CFG,
			`ACTRX_IDX_IMR, `ACTRX_IDX_BAUD, `ACTRX_IDX_ISR, `ACTRX_IDX_STAT: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Write response
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= `ACTRX_RESP_OKAY;
		end else if (wr_do) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out  <= wr_ok ? `ACTRX_RESP_OKAY : `ACTRX_RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// Software-written registers; status and interrupt status ignore writes
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			mode_r      <= `ACTRX_RST_MODE;
			timer_set_r <= `ACTRX_RST_TIMER;
			resume_r    <= `ACTRX_RST_RESUME;
			cfg_r       <= `ACTRX_RST_CFG;
			baud_r      <= `ACTRX_RST_BAUD;
			imr_r       <= 2'h0;
		end else if (wr_do && w_strb0_r) begin
			unique case (wr_idx)
				`ACTRX_IDX_MODE:   mode_r      <= w_data_r[7:0];
				`ACTRX_IDX_TIMER:  timer_set_r <= w_data_r[7:0];
				`ACTRX_IDX_RESUME: resume_r    <= w_data_r[7:0];
				`ACTRX_IDX_CFG:    cfg_r       <= w_data_r[7:0];
				`ACTRX_IDX_BAUD:   baud_r      <= w_data_r[7:0];
				`ACTRX_IDX_IMR:    imr_r       <= w_data_r[1:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		unique case (rd_idx)
			`ACTRX_IDX_MODE:   rd_data[7:0] = mode_r;
			`ACTRX_IDX_TIMER:  rd_data[7:0] = timer_set_r;
			`ACTRX_IDX_RESUME: rd_data[7:0] = resume_r;
			`ACTRX_IDX_CFG:    rd_data[7:0] = cfg_r;
			`ACTRX_IDX_BAUD:   rd_data[7:0] = baud_r;
			`ACTRX_IDX_ISR:    rd_data[1:0] = isr_r;
			`ACTRX_IDX_IMR:    rd_data[1:0] = imr_r;
			`ACTRX_IDX_STAT:   rd_data[2:0] = {tmr_state_r == ACTRX_TMR_RUN, xoff_state_r,
				~rts_b_out};
			default:           rd_ok = 1'b0;
		endcase
	end

	// Read channel: one read at a time, answer one cycle after address is taken
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0000_0000;
			s_axi_rresp_out   <= `ACTRX_RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rdata_out   <= rd_data;
			s_axi_rresp_out   <= rd_ok ? `ACTRX_RESP_OKAY : `ACTRX_RESP_SLVERR;
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out  <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end else if (!s_axi_rvalid_out) begin
			s_axi_arready_out <= 1'b1;
		end
	end

	// Interrupt status: read clears, a new event in the same cycle wins
	always_comb begin
		isr_nxt = isr_r;
		if (ar_take && rd_idx == `ACTRX_IDX_ISR) begin
			isr_nxt = 2'h0;
		end
		if (tmr_fire_r) begin
			isr_nxt[`ACTRX_INT_TIMER] = 1'b1; // RULE_06
		end
		if (resume_hit) begin
			isr_nxt[`ACTRX_INT_RESUME] = 1'b1; // RULE_15
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			isr_r   <= 2'h0;
			irq_out <= 1'b0;
		end else begin
			isr_r   <= isr_nxt;
			irq_out <= |(isr_nxt & imr_r);
		end
	end

	// Request to send, active low at the pin
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			rts_b_out <= 1'b1;
		end else if (mode_r[`ACTRX_MODE_RTS]) begin
			rts_b_out <= 1'b0; // RULE_02
		end else begin
			rts_b_out <= ~tx_busy_in; // RULE_01
		end
	end

	// Test loop: transmitter feeds own receiver, line held idle
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			tx_line_out   <= 1'b1;
			rx_serial_out <= 1'b1;
			rx_active_out <= 1'b0;
		end else begin
			tx_line_out   <= mode_r[`ACTRX_MODE_LOOP] ? 1'b1 : tx_serial_in; // RULE_04
			rx_serial_out <= mode_r[`ACTRX_MODE_LOOP] ? tx_serial_in : rx_line_in; // RULE_04
			rx_active_out <= mode_r[`ACTRX_MODE_RAC];
		end
	end

	// Baud generator on the crystal clock
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			baud_cnt_r      <= 8'h00;
			ovs_cnt_r       <= 4'h0;
			sample_tick_out <= 1'b0;
			bit_tick_out    <= 1'b0;
		end else if (baud_cnt_r == baud_r) begin
			baud_cnt_r      <= 8'h00;
			sample_tick_out <= 1'b1; // RULE_11
			ovs_cnt_r       <= ovs_cnt_r + 4'h1;
			bit_tick_out    <= (ovs_cnt_r == `ACTRX_OVS_M1); // RULE_11
		end else begin
			baud_cnt_r      <= baud_cnt_r + 8'h01;
			sample_tick_out <= 1'b0;
			bit_tick_out    <= 1'b0;
		end
	end

	// Crystal divided by four
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			xtal_div_r <= 2'h0;
		end else begin
			xtal_div_r <= xtal_div_r + 2'h1;
		end
	end

	always_comb begin
		if (!cfg_r[`ACTRX_CFG_MCE]) begin
			tmr_tick = tx_clk_tick_in; // RULE_08
		end else if (cfg_r[`ACTRX_CFG_CRYSTAL_DIVIDE_SELECT]) begin
			tmr_tick = (xtal_div_r == 2'h3); // RULE_10
		end else begin
			tmr_tick = 1'b1; // RULE_09
		end
	end

	assign k_m1 = mode_r[`ACTRX_MODE_TRS] ? `ACTRX_K_FINE_M1 : `ACTRX_K_COARSE_M1; // RULE_03
	assign t1_units = {3'h0, timer_set_r[`ACTRX_TMR_VAL_HI:0]} + 8'h01; // RULE_05
	assign t2_units = {timer_set_r[`ACTRX_TMR_CNT_HI:`ACTRX_TMR_CNT_LO], 5'h00}
		+ t1_units; // RULE_06
	assign tmr_periodic = (timer_set_r[`ACTRX_TMR_CNT_HI:`ACTRX_TMR_CNT_LO]
		== `ACTRX_TMR_PERIODIC);
	assign tmr_units_nxt = tmr_units_r + 8'h01;

	// Timer: a write to the period register (re)starts it
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			tmr_state_r <= ACTRX_TMR_IDLE;
			tmr_pre_r   <= 15'h0000;
			tmr_units_r <= 8'h00;
			tmr_fire_r  <= 1'b0;
		end else if (wr_do && w_strb0_r && wr_idx == `ACTRX_IDX_TIMER) begin
			tmr_state_r <= ACTRX_TMR_RUN;
			tmr_pre_r   <= 15'h0000;
			tmr_units_r <= 8'h00;
			tmr_fire_r  <= 1'b0;
		end else begin
			tmr_fire_r <= 1'b0;
			unique case (tmr_state_r)
				ACTRX_TMR_IDLE: ;
				ACTRX_TMR_RUN: begin
					if (tmr_tick) begin
						if (tmr_pre_r == k_m1) begin
							tmr_pre_r <= 15'h0000;
							if (tmr_periodic && tmr_units_nxt == t1_units) begin
								tmr_units_r <= 8'h00; // RULE_07
								tmr_fire_r  <= 1'b1; // RULE_07
							end else if (!tmr_periodic && tmr_units_nxt == t2_units) begin
								tmr_units_r <= 8'h00; // RULE_06
								tmr_fire_r  <= 1'b1; // RULE_06
								tmr_state_r <= ACTRX_TMR_IDLE;
							end else begin
								tmr_units_r <= tmr_units_nxt;
							end
						end else begin
							tmr_pre_r <= tmr_pre_r + 15'h0001;
						end
					end
				end
			endcase
		end
	end

	// Significant bits of the resume character by programmed length
	always_comb begin
		unique case (cfg_r[`ACTRX_CFG_LEN_HI:`ACTRX_CFG_LEN_LO])
			2'h0: len_mask = 8'h1f;
			2'h1: len_mask = 8'h3f;
			2'h2: len_mask = 8'h7f;
			2'h3: len_mask = 8'hff;
		endcase
	end

	assign resume_hit = rx_char_valid_in & rx_frame_ok_in // RULE_13
		& (rx_parity_ok_in | ~cfg_r[`ACTRX_CFG_PAR_EN]) // RULE_13
		& (((rx_char_in ^ resume_r) & len_mask) == 8'h00); // RULE_12

	// Every received character goes on to the receive FIFO
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			rx_fifo_wr_out   <= 1'b0;
			rx_fifo_data_out <= 8'h00;
		end else begin
			rx_fifo_wr_out   <= rx_char_valid_in; // RULE_14
			rx_fifo_data_out <= rx_char_in; // RULE_14
		end
	end

	// In-band flow control: stop character halts, resume character restarts
	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			xoff_state_r  <= 1'b0;
			tx_enable_out <= 1'b1;
		end else if (!mode_r[`ACTRX_MODE_INBAND_FLOW_ENABLE]) begin
			xoff_state_r  <= 1'b0;
			tx_enable_out <= 1'b1;
		end else if (resume_hit) begin
			xoff_state_r  <= 1'b0; // RULE_16
			tx_enable_out <= 1'b1; // RULE_16
		end else if (stop_char_in) begin
			xoff_state_r  <= 1'b1;
			tx_enable_out <= 1'b0;
		end
	end

endmodule : actrx_top
`default_nettype wire
